//--- common/codr_pkg.sv
// constants shared by the clock output divider and routing stage
package codr_pkg;

  // source select codes for outputs a through d
  localparam logic [2:0] SRC_REF        = 3'h0;
  localparam logic [2:0] SRC_RESERVED   = 3'h1;
  localparam logic [2:0] SRC_FIRST_PLL_0     = 3'h2;
  localparam logic [2:0] SRC_FIRST_PLL_180   = 3'h3;
  localparam logic [2:0] SRC_SECOND_PLL_0     = 3'h4;
  localparam logic [2:0] SRC_SECOND_PLL_180   = 3'h5;
  localparam logic [2:0] SRC_THIRD_PLL_0     = 3'h6;
  localparam logic [2:0] SRC_THIRD_PLL_180   = 3'h7;

  // output e post divider codes
  localparam logic [1:0] E_OFF          = 2'h0;
  localparam logic [1:0] E_DIV4         = 2'h1;
  localparam logic [1:0] E_DIV2         = 2'h2;
  localparam logic [1:0] E_DIV3         = 2'h3;

  // divider ratios
  localparam logic [6:0] DIV_OFF        = 7'h00;
  localparam logic [6:0] DIV_ONE        = 7'h01;
  localparam logic [6:0] RATIO_4        = 7'h04;
  localparam logic [6:0] RATIO_2        = 7'h02;
  localparam logic [6:0] RATIO_3        = 7'h03;

  // pll index values returned by the source decode (0 means reference)
  localparam logic [1:0] PLL_NONE       = 2'h0;
  localparam logic [1:0] PLL_FIRST      = 2'h1;
  localparam logic [1:0] PLL_SECOND     = 2'h2;
  localparam logic [1:0] PLL_THIRD      = 2'h3;

  // divider slots and output slots
  localparam int         NUM_MAIN       = 4;
  localparam int         NUM_DIV        = 5;
  localparam int         NUM_OUT        = 6;
  localparam int         SLOT_D         = 3;
  localparam int         SLOT_E         = 4;
  localparam int         SLOT_X         = 5;

  // pll p and q settings: three bytes per pll
  localparam logic [1:0] PQ_BYTES       = 2'h3;

  // start-up capture of the two serial pin levels
  localparam logic [1:0] BOOT_CAPTURE   = 2'h3;

  // reset values
  localparam logic [5:0] OSC_CAP_RESET  = 6'h00;
  localparam logic [7:0] PQ_RESET       = 8'h00;
  localparam logic [2:0] ROW_RESET      = 3'h0;

endpackage

//--- hdl/codr_output_router.sv
// crossbar, output dividers, power control and pll setting capture of the clock generator
`timescale 1ns/100ps
module codr_output_router (
  input  wire logic        CLK,                          // 40 MHz system clock
  input  wire logic        RST_B,                        // async reset, active low
  input  wire logic        REF_CLK,                      // reference clock level
  input  wire logic        FIRST_PLL_CLK,                // first pll 0 degree level
  input  wire logic        SECOND_PLL_CLK,               // second pll 0 degree level
  input  wire logic        THIRD_PLL_CLK,                // third pll 0 degree level
  input  wire logic        FIRST_SELECT_INPUT,           // serial data pin level
  input  wire logic        SECOND_SELECT_INPUT,          // serial clock pin level
  input  wire logic        THIRD_SELECT_SUSPEND_INPUT,   // third select or suspend pin
  input  wire logic        POWER_DOWN_ENABLE_PIN,        // shutdown or output enable pin
  input  wire logic        PIN_FUNCTION_SELECT,          // 1: shutdown, 0: output enable
  input  wire logic        SUSPEND_MODE_ENABLE,          // third pin acts as suspend
  input  wire logic [2:0]  SUSPEND_PLL_MASK,             // plls stopped by suspend
  input  wire logic [5:0]  SUSPEND_OUTPUT_MASK,          // a..e, buffer tristated by suspend
  input  wire logic [2:0]  PLL_ENABLE,                   // per pll enable
  input  wire logic        XBUF_ENABLE,                  // reference buffer enable
  input  wire logic        DIFF_VARIANT,                 // differential output variant
  input  wire logic [7:0]  BANK_TABLE,                   // bank select per table row
  input  wire logic [6:0]  OUTPUT_A_DIVIDER_0,           // output a divider, bank 0
  input  wire logic [6:0]  OUTPUT_A_DIVIDER_1,           // output a divider, bank 1
  input  wire logic [6:0]  OUTPUT_B_DIVIDER_0,           // output b divider, bank 0
  input  wire logic [6:0]  OUTPUT_B_DIVIDER_1,           // output b divider, bank 1
  input  wire logic [6:0]  OUTPUT_C_DIVIDER,             // output c divider
  input  wire logic [6:0]  OUTPUT_D_DIVIDER,             // output d divider
  input  wire logic [2:0]  OUTPUT_A_SOURCE,              // source select code a
  input  wire logic [2:0]  OUTPUT_B_SOURCE,              // source select code b
  input  wire logic [2:0]  OUTPUT_C_SOURCE,              // source select code c
  input  wire logic [2:0]  OUTPUT_D_SOURCE,              // source select code d
  input  wire logic [1:0]  E_POST_DIVIDER_CODE,          // output e post divider code
  input  wire logic [5:0]  OSC_CAP_DATA,                 // load capacitor value
  input  wire logic        OSC_CAP_WRITE,                // load capacitor write strobe
  input  wire logic [1:0]  PQ_PLL,                       // pll number 1..3
  input  wire logic [1:0]  PQ_BYTE,                      // byte number 0..2
  input  wire logic [7:0]  PQ_DATA,                      // byte value
  input  wire logic        PQ_ACK,                       // acknowledge of that byte
  output logic             OUTPUT_A,                     // output a data
  output logic             OUTPUT_A_OE,                  // output a enable
  output logic             OUTPUT_B,                     // output b data
  output logic             OUTPUT_B_OE,                  // output b enable
  output logic             OUTPUT_C,                     // output c data
  output logic             OUTPUT_C_OE,                  // output c enable
  output logic             OUTPUT_D,                     // output d data
  output logic             OUTPUT_D_OE,                  // output d enable
  output logic             OUTPUT_E,                     // output e data
  output logic             OUTPUT_E_OE,                  // output e enable
  output logic             XBUF_OUT,                     // buffered reference
  output logic             XBUF_OE,                      // buffered reference enable
  output logic [2:0]       PLL_RUN,                      // pll running flags
  output logic             OSC_RUN,                      // reference oscillator running
  output logic [2:0]       FREQ_ROW,                     // frequency table row
  output logic             DIVIDER_BANK_SELECT,          // a/b divider bank in use
  output logic [5:0]       OSC_LOAD_CAP,                 // load capacitor setting
  output logic [23:0]      FIRST_PLL_PQ,                 // first pll p and q bytes
  output logic [23:0]      SECOND_PLL_PQ,                // second pll p and q bytes
  output logic [23:0]      THIRD_PLL_PQ                  // third pll p and q bytes
);

  // whole state of the block
  typedef struct packed {
    logic [3:0]            src_meta;                     // source sync, first stage
    logic [3:0]            src_sync;                     // source sync, second stage
    logic [1:0]            sel_meta;                     // serial pins, first stage
    logic [1:0]            sel_sync;                     // serial pins, second stage
    logic                  s2_meta;                      // third pin, first stage
    logic                  s2_sync;                      // third pin, second stage
    logic                  pin_meta;                     // power pin, first stage
    logic                  pin_sync;                     // power pin, second stage
    logic [1:0]            boot;                         // start-up capture counter
    logic [1:0]            sel_latched;                  // captured serial pin levels
    logic [2:0]            row;                          // frequency table row
    logic                  bank;                         // divider bank in use
    logic [4:0]            prev;                         // last seen selected source level
    logic [4:0][6:0]       cnt;                          // edge counters
    logic [4:0]            clk;                          // divided clocks
    logic [5:0]            out_data;                     // registered pin data
    logic [5:0]            out_en;                       // registered pin enables
    logic [2:0]            run;                          // pll running
    logic                  osc;                          // oscillator running
    logic [5:0]            cap;                          // load capacitor value
    logic [2:0][2:0][7:0]  pq;                           // pll p and q bytes
  } codr_state_type;

  codr_state_type st;                                    // current state
  codr_state_type next_st;                               // next state

  // reserved code reads as flat low
  // level of the selected crossbar source; inverted pll phase by code
  function automatic logic codr_src_level(input logic [2:0] code, input logic [3:0] lvl);
    logic r;
    r = 1'b0;
    unique case (code)
      codr_pkg::SRC_REF:      r = lvl[0];
      codr_pkg::SRC_RESERVED: r = 1'b0;                  // reserved code gives no clock
      codr_pkg::SRC_FIRST_PLL_0:   r = lvl[1];
      codr_pkg::SRC_FIRST_PLL_180: r = ~lvl[1];
      codr_pkg::SRC_SECOND_PLL_0:   r = lvl[2];
      codr_pkg::SRC_SECOND_PLL_180: r = ~lvl[2];
      codr_pkg::SRC_THIRD_PLL_0:   r = lvl[3];
      codr_pkg::SRC_THIRD_PLL_180: r = ~lvl[3];
    endcase
    return r;
  endfunction

  // lets a stopped pll kill its outputs
  // which pll a source code depends on
  function automatic logic [1:0] codr_src_pll(input logic [2:0] code);
    logic [1:0] p;
    p = codr_pkg::PLL_NONE;
    unique case (code)
      codr_pkg::SRC_REF, codr_pkg::SRC_RESERVED:     p = codr_pkg::PLL_NONE;
      codr_pkg::SRC_FIRST_PLL_0, codr_pkg::SRC_FIRST_PLL_180:  p = codr_pkg::PLL_FIRST;
      codr_pkg::SRC_SECOND_PLL_0, codr_pkg::SRC_SECOND_PLL_180:  p = codr_pkg::PLL_SECOND;
      codr_pkg::SRC_THIRD_PLL_0, codr_pkg::SRC_THIRD_PLL_180:  p = codr_pkg::PLL_THIRD;
    endcase
    return p;
  endfunction

  // code 00 gives ratio zero: e is off unless the differential variant is set
  // output e ratio from its post divider code
  function automatic logic [6:0] codr_e_ratio(input logic [1:0] code);
    logic [6:0] r;
    r = codr_pkg::DIV_OFF;
    unique case (code)
      codr_pkg::E_OFF:  r = codr_pkg::DIV_OFF;
      codr_pkg::E_DIV4: r = codr_pkg::RATIO_4;
      codr_pkg::E_DIV2: r = codr_pkg::RATIO_2;
      codr_pkg::E_DIV3: r = codr_pkg::RATIO_3;
    endcase
    return r;
  endfunction

  // helpers, set on every pass
  logic [3:0][2:0] src_code;                             // source codes a..d
  logic [3:0][6:0] main_div;                             // selected ratios a..d
  logic [4:0][6:0] ratio;                                // ratios a..e
  logic [4:0]      sel_lvl;                              // selected levels a..e
  logic [4:0]      dep_ok;                               // source of the slot is running
  logic [3:0]      lvl;                                  // gated source levels
  logic            pin_low;                              // power pin asserted low
  logic            full_stop;                            // system shutdown in force
  logic            susp;                                 // suspend in force
  logic [1:0]      dep_pll;                              // pll a slot depends on
  logic [5:0]      slot_en;                              // outputs allowed to drive

  // bank swaps a and b ratios together
  // gather per-output settings; bank picks both a and b at once
  always_comb begin
    src_code[0] = OUTPUT_A_SOURCE;
    src_code[1] = OUTPUT_B_SOURCE;
    src_code[2] = OUTPUT_C_SOURCE;
    src_code[3] = OUTPUT_D_SOURCE;
    main_div[0] = st.bank ? OUTPUT_A_DIVIDER_1 : OUTPUT_A_DIVIDER_0;
    main_div[1] = st.bank ? OUTPUT_B_DIVIDER_1 : OUTPUT_B_DIVIDER_0;
    main_div[2] = OUTPUT_C_DIVIDER;
    main_div[3] = OUTPUT_D_DIVIDER;
  end

  // next state: syncs, power control, dividers, setting capture
  always_comb begin
    next_st = st;
    dep_pll = codr_pkg::PLL_NONE;
    // two-flop synchronisers for every pin level
    next_st.src_meta = {THIRD_PLL_CLK, SECOND_PLL_CLK, FIRST_PLL_CLK, REF_CLK};
    next_st.src_sync = st.src_meta;
    next_st.sel_meta = {SECOND_SELECT_INPUT, FIRST_SELECT_INPUT};
    next_st.sel_sync = st.sel_meta;
    next_st.s2_meta  = THIRD_SELECT_SUSPEND_INPUT;
    next_st.s2_sync  = st.s2_meta;
    next_st.pin_meta = POWER_DOWN_ENABLE_PIN;
    next_st.pin_sync = st.pin_meta;

    // pins are only read past the syncs
    // pin low tristates always; with function bit high it also stops everything
    pin_low   = ~st.pin_sync;
    full_stop = pin_low & PIN_FUNCTION_SELECT;
    susp      = SUSPEND_MODE_ENABLE & ~st.s2_sync;

    // shutdown overrides every enable
    // a pll runs only when enabled, not shut down and not suspended
    for (int p = 0; p < 3; p++) begin
      next_st.run[p] = PLL_ENABLE[p] & ~full_stop & ~(susp & SUSPEND_PLL_MASK[p]);
    end
    next_st.osc = ~full_stop;

    // a stopped pll or oscillator contributes a flat level
    lvl = {st.src_sync[3:1] & st.run, st.src_sync[0] & st.osc};

    // start-up capture of the serial pin levels, once the syncs have filled;
    // the second stage holds its reset value until
    // the second edge, so take it on the third
    if (st.boot != codr_pkg::BOOT_CAPTURE) begin
      next_st.boot = st.boot + 2'h1;
      if (st.boot + 2'h1 == codr_pkg::BOOT_CAPTURE) begin
        next_st.sel_latched = st.sel_sync;
      end
    end
    // table row: third select only counts when not used as suspend
    next_st.row  = {st.s2_sync & ~SUSPEND_MODE_ENABLE, st.sel_latched};
    next_st.bank = BANK_TABLE[st.row];

    // slots 0 to 3 crossbar, slot 4 is e
    // per-slot ratio, source level and dependency
    for (int i = 0; i < codr_pkg::NUM_DIV; i++) begin
      if (i < codr_pkg::NUM_MAIN) begin
        ratio[i]   = main_div[i];
        sel_lvl[i] = codr_src_level(src_code[i], lvl);
        dep_pll    = codr_src_pll(src_code[i]);
      end else begin
        ratio[i]   = codr_e_ratio(E_POST_DIVIDER_CODE);
        sel_lvl[i] = lvl[1];
        dep_pll    = codr_pkg::PLL_FIRST;
      end
      // a disabled first pll turns off its dependants automatically
      dep_ok[i] = (dep_pll == codr_pkg::PLL_NONE) ? st.osc : st.run[dep_pll - 2'h1];
    end

    // limitation: no glitch guard on rewrites
    // dividers count both source edges and toggle every ratio edges,
    // so odd ratios still come out at half duty; ratio changes act at once
    for (int i = 0; i < codr_pkg::NUM_DIV; i++) begin
      next_st.prev[i] = sel_lvl[i];
      if (ratio[i] == codr_pkg::DIV_OFF || !dep_ok[i] || full_stop) begin
        next_st.cnt[i] = codr_pkg::DIV_OFF;
        next_st.clk[i] = 1'b0;
      end else if (sel_lvl[i] != st.prev[i]) begin
        // >= guards against a ratio lowered below the running count
        if (st.cnt[i] >= ratio[i] - codr_pkg::DIV_ONE) begin
          next_st.cnt[i] = codr_pkg::DIV_OFF;
          next_st.clk[i] = ~st.clk[i];
        end else begin
          next_st.cnt[i] = st.cnt[i] + codr_pkg::DIV_ONE;
        end
      end
    end

    // pin data lags the divider by a cycle
    // output data: divided clocks, differential variant bypass, reference copy
    for (int i = 0; i < codr_pkg::NUM_DIV; i++) begin
      next_st.out_data[i] = st.clk[i];
    end
    if (DIFF_VARIANT) begin
      next_st.out_data[codr_pkg::SLOT_E] = lvl[1];
      next_st.out_data[codr_pkg::SLOT_D] = ~lvl[1];
    end
    next_st.out_data[codr_pkg::SLOT_X] = lvl[0];

    // enables registered beside the data
    // output enables: divider on, or differential variant for d and e, or buffer enable; source running, not suspended, pin high
    for (int i = 0; i < codr_pkg::NUM_DIV; i++) begin
      slot_en[i] = (ratio[i] != codr_pkg::DIV_OFF) & dep_ok[i];
    end
    if (DIFF_VARIANT) begin
      slot_en[codr_pkg::SLOT_E] = st.run[0];
      slot_en[codr_pkg::SLOT_D] = st.run[0];
    end
    slot_en[codr_pkg::SLOT_X] = XBUF_ENABLE & st.osc;
    for (int i = 0; i < codr_pkg::NUM_OUT; i++) begin
      next_st.out_en[i] = slot_en[i] & ~pin_low & ~(susp & SUSPEND_OUTPUT_MASK[i]);
    end

    // no clock logic reads the cap value
    // load capacitor: writable any time, even with the pin low
    if (OSC_CAP_WRITE) begin
      next_st.cap = OSC_CAP_DATA;
    end

    // each p/q byte lands at its own acknowledge; the host keeps the pll
    // disabled meanwhile, since partial settings can be out of range
    if (PQ_ACK && PQ_PLL != codr_pkg::PLL_NONE && PQ_BYTE < codr_pkg::PQ_BYTES) begin
      next_st.pq[PQ_PLL - 2'h1][PQ_BYTE] = PQ_DATA;
    end
  end

  // state register
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      st             <= '0;
      st.row         <= codr_pkg::ROW_RESET;
      st.cap         <= codr_pkg::OSC_CAP_RESET;
      st.pq          <= {9{codr_pkg::PQ_RESET}};
    end else begin
      st             <= next_st;
    end
  end

  // slot order: a, b, c, d, e, buffer
  // outputs straight from flops
  always_comb begin
    OUTPUT_A            = st.out_data[0];
    OUTPUT_A_OE         = st.out_en[0];
    OUTPUT_B            = st.out_data[1];
    OUTPUT_B_OE         = st.out_en[1];
    OUTPUT_C            = st.out_data[2];
    OUTPUT_C_OE         = st.out_en[2];
    OUTPUT_D            = st.out_data[codr_pkg::SLOT_D];
    OUTPUT_D_OE         = st.out_en[codr_pkg::SLOT_D];
    OUTPUT_E            = st.out_data[codr_pkg::SLOT_E];
    OUTPUT_E_OE         = st.out_en[codr_pkg::SLOT_E];
    XBUF_OUT            = st.out_data[codr_pkg::SLOT_X];
    XBUF_OE             = st.out_en[codr_pkg::SLOT_X];
    PLL_RUN             = st.run;
    OSC_RUN             = st.osc;
    FREQ_ROW            = st.row;
    DIVIDER_BANK_SELECT = st.bank;
    OSC_LOAD_CAP        = st.cap;
    FIRST_PLL_PQ        = st.pq[0];
    SECOND_PLL_PQ       = st.pq[1];
    THIRD_PLL_PQ        = st.pq[2];
  end

endmodule

//--- testbench/codr_checker.sv
// concurrent checks on the ports of the clock output divider and routing stage
`timescale 1ns/100ps
module codr_checker (
  input wire logic        CLK,
  input wire logic        RST_B,
  input wire logic        THIRD_SELECT_SUSPEND_INPUT,
  input wire logic        POWER_DOWN_ENABLE_PIN,
  input wire logic        PIN_FUNCTION_SELECT,
  input wire logic        SUSPEND_MODE_ENABLE,
  input wire logic [2:0]  SUSPEND_PLL_MASK,
  input wire logic [5:0]  SUSPEND_OUTPUT_MASK,
  input wire logic [2:0]  PLL_ENABLE,
  input wire logic        DIFF_VARIANT,
  input wire logic [7:0]  BANK_TABLE,
  input wire logic [6:0]  OUTPUT_C_DIVIDER,
  input wire logic [1:0]  E_POST_DIVIDER_CODE,
  input wire logic [5:0]  OSC_CAP_DATA,
  input wire logic        OSC_CAP_WRITE,
  input wire logic [1:0]  PQ_PLL,
  input wire logic [1:0]  PQ_BYTE,
  input wire logic [7:0]  PQ_DATA,
  input wire logic        PQ_ACK,
  input wire logic        OUTPUT_A_OE,
  input wire logic        OUTPUT_C_OE,
  input wire logic        OUTPUT_D,
  input wire logic        OUTPUT_D_OE,
  input wire logic        OUTPUT_E,
  input wire logic        OUTPUT_E_OE,
  input wire logic [2:0]  PLL_RUN,
  input wire logic        OSC_RUN,
  input wire logic [2:0]  FREQ_ROW,
  input wire logic        DIVIDER_BANK_SELECT,
  input wire logic [5:0]  OSC_LOAD_CAP,
  input wire logic [23:0] THIRD_PLL_PQ
);
  logic [2:0] up_cnt;  // edges since reset release, saturating; bank needs row settled first
  // count up after reset
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      up_cnt <= 3'h0;
    end else if (up_cnt != 3'h7) begin
      up_cnt <= up_cnt + 3'h1;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // pin paths pass a two flop sync, so five samples cover the latency
  sequence s_pin_low; !POWER_DOWN_ENABLE_PIN [*5]; endsequence
  sequence s_shutdown; (PIN_FUNCTION_SELECT && !POWER_DOWN_ENABLE_PIN) [*5]; endsequence
  sequence s_susp_c;
    (SUSPEND_MODE_ENABLE && !THIRD_SELECT_SUSPEND_INPUT && SUSPEND_OUTPUT_MASK[2]) [*5];
  endsequence
  sequence s_susp_p;
    (SUSPEND_MODE_ENABLE && !THIRD_SELECT_SUSPEND_INPUT && SUSPEND_PLL_MASK[0]) [*5];
  endsequence
  AST_PIN_TRISTATE: assert property (s_pin_low |-> !(OUTPUT_A_OE || OUTPUT_C_OE || OUTPUT_E_OE))
    else $error("outputs driven while enable pin low");
  AST_SHUTDOWN_STOP: assert property (s_shutdown |-> PLL_RUN == 3'h0 && !OSC_RUN)
    else $error("plls or oscillator run in shutdown");
  AST_SUSPEND_OUT: assert property (s_susp_c |-> !OUTPUT_C_OE)
    else $error("suspended output still driven");
  AST_SUSPEND_PLL: assert property (s_susp_p |-> !PLL_RUN[0])
    else $error("suspended pll still running");
  AST_PLL_DISABLE: assert property (!PLL_ENABLE[2] [*2] |-> !PLL_RUN[2])
    else $error("disabled pll still running");
  AST_C_ZERO_OFF: assert property ((OUTPUT_C_DIVIDER == 7'h00) [*2] |-> !OUTPUT_C_OE)
    else $error("zero ratio output driven");
  AST_E_OFF: assert property ((E_POST_DIVIDER_CODE == 2'h0 && !DIFF_VARIANT) [*2] |-> !OUTPUT_E_OE)
    else $error("output e driven with code off");
  AST_DIFF_PAIR: assert property (DIFF_VARIANT [*3] ##0 OUTPUT_E_OE |-> OUTPUT_D_OE && OUTPUT_D != OUTPUT_E)
    else $error("output d not complement of e");
  AST_PQ_BYTE: assert property (PQ_ACK && PQ_PLL == 2'h3 && PQ_BYTE != 2'h3
    |=> THIRD_PLL_PQ[8*$past(PQ_BYTE) +: 8] == $past(PQ_DATA))
    else $error("pll byte not taken at acknowledge");
  AST_CAP_WRITE: assert property (OSC_CAP_WRITE |=> OSC_LOAD_CAP == $past(OSC_CAP_DATA))
    else $error("load capacitor write lost");
  AST_BANK: assert property (up_cnt == 3'h7 && $stable(BANK_TABLE) && $stable(FREQ_ROW)
    |-> DIVIDER_BANK_SELECT == BANK_TABLE[FREQ_ROW])
    else $error("bank select differs from table");
endmodule
bind codr_output_router codr_checker codr_checker_inst (.*);

//--- testbench/codr_host_model.sv
// host model driving the pll setting and load capacitor capture ports
`timescale 1ns/100ps
module codr_host_model (
  input  wire logic  CLK,
  output logic [1:0] PQ_PLL,
  output logic [1:0] PQ_BYTE,
  output logic [7:0] PQ_DATA,
  output logic       PQ_ACK,
  output logic [5:0] OSC_CAP_DATA,
  output logic       OSC_CAP_WRITE
);
  // idle lines at time zero
  initial begin
    {PQ_PLL, PQ_BYTE, PQ_DATA, PQ_ACK, OSC_CAP_DATA, OSC_CAP_WRITE} = '0;
  end
  // one byte per acknowledge pulse; data inverted after release, not held
  task automatic pq(input logic [1:0] pll, input logic [1:0] idx, input logic [7:0] d);
    @(posedge CLK);
    #1;
    {PQ_PLL, PQ_BYTE, PQ_DATA, PQ_ACK} = {pll, idx, d, 1'b1};
    @(posedge CLK);
    #1;
    PQ_ACK = 1'b0;
    PQ_DATA = ~d;
  endtask
  // load capacitor rewrite, allowed at any time
  task automatic cap(input logic [5:0] d);
    @(posedge CLK);
    #1;
    {OSC_CAP_DATA, OSC_CAP_WRITE} = {d, 1'b1};
    @(posedge CLK);
    #1;
    OSC_CAP_WRITE = 1'b0;
    OSC_CAP_DATA = ~d;
  endtask
endmodule

//--- testbench/testbench.sv
// self-checking bench for the clock output divider and routing stage
`timescale 1ns/100ps
module testbench;
  logic CLK, RST_B, REF_CLK, FIRST_PLL_CLK, SECOND_PLL_CLK, THIRD_PLL_CLK, XBUF_OUT, XBUF_OE;
  logic FIRST_SELECT_INPUT, SECOND_SELECT_INPUT, THIRD_SELECT_SUSPEND_INPUT, DIFF_VARIANT;
  logic POWER_DOWN_ENABLE_PIN, PIN_FUNCTION_SELECT, SUSPEND_MODE_ENABLE, XBUF_ENABLE;
  logic OSC_CAP_WRITE, PQ_ACK, DIVIDER_BANK_SELECT, OSC_RUN, OUTPUT_A, OUTPUT_A_OE, OUTPUT_B;
  logic OUTPUT_B_OE, OUTPUT_C, OUTPUT_C_OE, OUTPUT_D, OUTPUT_D_OE, OUTPUT_E, OUTPUT_E_OE;
  logic [2:0] SUSPEND_PLL_MASK, PLL_ENABLE, OUTPUT_A_SOURCE, OUTPUT_B_SOURCE, PLL_RUN;
  logic [2:0] OUTPUT_C_SOURCE, OUTPUT_D_SOURCE, FREQ_ROW;
  logic [5:0] SUSPEND_OUTPUT_MASK, OSC_CAP_DATA, OSC_LOAD_CAP;
  logic [6:0] OUTPUT_A_DIVIDER_0, OUTPUT_A_DIVIDER_1, OUTPUT_B_DIVIDER_0, OUTPUT_B_DIVIDER_1;
  logic [6:0] OUTPUT_C_DIVIDER, OUTPUT_D_DIVIDER;
  logic [7:0] BANK_TABLE, PQ_DATA;
  logic [1:0] E_POST_DIVIDER_CODE, PQ_PLL, PQ_BYTE;
  logic [23:0] FIRST_PLL_PQ, SECOND_PLL_PQ, THIRD_PLL_PQ;
  int err_total = 0, n_checks = 0, cyc = 0, src_cnt = 0, w;
  typedef struct {logic [2:0] src; logic [6:0] cdiv; logic [1:0] ecode; int ch; int eh;} codr_row_type;
  // sources toggle every 4 cycles, so a ratio r gives half periods of 4r cycles
  codr_row_type rows [5] = '{'{3'h0, 7'h01, 2'h2, 4, 8}, '{3'h2, 7'h03, 2'h3, 12, 12},
    '{3'h3, 7'h02, 2'h1, 8, 16}, '{3'h4, 7'h7F, 2'h0, 508, 0}, '{3'h7, 7'h00, 2'h2, 0, 8}};
  codr_output_router codr_output_router_inst (.*);
  codr_host_model codr_host_model_inst (.*);
  always #12.5 CLK = ~CLK;
  // slow source clocks and hang limit
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
    #1;
    src_cnt = (src_cnt + 1) % 4;
    if (src_cnt == 0) begin
      {REF_CLK, FIRST_PLL_CLK, SECOND_PLL_CLK, THIRD_PLL_CLK} = ~{4{REF_CLK}};
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // {enable, data} of output c, e, a or the buffer
  function automatic logic [1:0] pick(input logic [1:0] s);
    return (s == 2'h0) ? {OUTPUT_C_OE, OUTPUT_C} : (s == 2'h1) ? {OUTPUT_E_OE, OUTPUT_E} :
      (s == 2'h2) ? {OUTPUT_A_OE, OUTPUT_A} : {XBUF_OE, XBUF_OUT};
  endfunction
  // cycles until the selected output changes level
  task automatic half(input logic [1:0] s, output int n);
    logic [1:0] v;
    n = 0;
    v = pick(s);
    while (pick(s) === v && n < 2100) begin
      @(posedge CLK);
      #1;
      n++;
    end
  endtask
  // first change may be partial
  task automatic measure(input logic [1:0] s, input int exp);
    repeat (8) @(posedge CLK);
    #1;
    if (exp == 0) begin
      chk(pick(s) >> 1, 0);
    end else begin
      repeat (2) half(s, w);
      chk(w, exp);
      half(s, w);
      chk(w, exp);
    end
  endtask
  task automatic settle(input logic [6:0] t);
    repeat (t) @(posedge CLK);
    #1;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    {CLK, RST_B, REF_CLK, FIRST_PLL_CLK, SECOND_PLL_CLK, THIRD_PLL_CLK} = '0;
    {FIRST_SELECT_INPUT, SECOND_SELECT_INPUT, THIRD_SELECT_SUSPEND_INPUT, DIFF_VARIANT} = 4'h8;
    {POWER_DOWN_ENABLE_PIN, PIN_FUNCTION_SELECT, XBUF_ENABLE, SUSPEND_MODE_ENABLE} = 4'hE;
    {SUSPEND_PLL_MASK, SUSPEND_OUTPUT_MASK, PLL_ENABLE, BANK_TABLE} = {9'h000, 3'h7, 8'h20};
    {OUTPUT_A_SOURCE, OUTPUT_B_SOURCE, OUTPUT_C_SOURCE, OUTPUT_D_SOURCE} = '0;
    {OUTPUT_A_DIVIDER_0, OUTPUT_B_DIVIDER_0, OUTPUT_C_DIVIDER, OUTPUT_D_DIVIDER} = {4{7'h02}};
    {OUTPUT_A_DIVIDER_1, OUTPUT_B_DIVIDER_1, E_POST_DIVIDER_CODE} = {7'h05, 7'h05, 2'h0};
    settle(5);
    chk({OUTPUT_A_OE, OUTPUT_C_OE, XBUF_OE, PLL_RUN, OSC_RUN, FREQ_ROW}, 0);
    RST_B = 1'b1;
    settle(4);
    FIRST_SELECT_INPUT = 1'b0;
    foreach (rows[i]) begin
      settle(1);
      {OUTPUT_C_SOURCE, OUTPUT_C_DIVIDER} = {rows[i].src, rows[i].cdiv};
      E_POST_DIVIDER_CODE = rows[i].ecode;
      measure(2'h0, rows[i].ch);
      measure(2'h1, rows[i].eh);
      $display("row %0d done", i);
    end
    measure(2'h2, 8);
    chk({FREQ_ROW, DIVIDER_BANK_SELECT}, 4'h2);
    THIRD_SELECT_SUSPEND_INPUT = 1'b1;
    settle(8);
    chk({FREQ_ROW, DIVIDER_BANK_SELECT}, 4'hB);
    measure(2'h2, 20);
    $display("bank test done");
    PLL_ENABLE = 3'h2;
    codr_host_model_inst.pq(2'h3, 2'h2, 8'hA5);
    codr_host_model_inst.pq(2'h3, 2'h0, 8'h3C);
    codr_host_model_inst.pq(2'h0, 2'h1, 8'hFF);
    codr_host_model_inst.pq(2'h1, 2'h1, 8'h5A);
    settle(2);
    chk({THIRD_PLL_PQ, PLL_RUN}, {24'hA5003C, 3'h2});
    chk({FIRST_PLL_PQ[15:8], SECOND_PLL_PQ}, 32'h5A000000);
    PLL_ENABLE = 3'h7;
    POWER_DOWN_ENABLE_PIN = 1'b0;
    codr_host_model_inst.cap(6'h2A);
    settle(6);
    chk({OSC_LOAD_CAP, OUTPUT_A_OE, OUTPUT_C_OE, XBUF_OE, PLL_RUN, OSC_RUN}, 13'h1500);
    PIN_FUNCTION_SELECT = 1'b0;
    settle(6);
    chk({XBUF_OE, PLL_RUN, OSC_RUN}, 5'h0F);
    POWER_DOWN_ENABLE_PIN = 1'b1;
    settle(6);
    chk(XBUF_OE, 1);
    measure(2'h3, 4);
    $display("power test done");
    OUTPUT_C_DIVIDER = 7'h01;
    {SUSPEND_MODE_ENABLE, SUSPEND_PLL_MASK, SUSPEND_OUTPUT_MASK} = {1'b1, 3'h1, 6'h14};
    THIRD_SELECT_SUSPEND_INPUT = 1'b0;
    settle(6);
    chk({PLL_RUN, OUTPUT_E_OE, OUTPUT_A_OE, OUTPUT_C_OE}, 6'h32);
    {SUSPEND_MODE_ENABLE, DIFF_VARIANT, E_POST_DIVIDER_CODE} = 4'h4;
    settle(6);
    chk({OUTPUT_D_OE, OUTPUT_E_OE, OUTPUT_D ^ OUTPUT_E}, 3'h7);
    $display("suspend and differential test done");
    end_of_test();
  end
endmodule
